/* File: rtl/fercc_top.sv */
// How it works
// - a failed user array erase sets erase_exec_error at bit 5; 0 is normal end
// - changing flash control registers during an erase sets erase_exec_error
// - user array erase while array_select_reg holds AA flags erase_exec_error
// - on that mismatched selection neither array is touched
// - user boot array erase only in boot or programmer mode
// - key register compared with 5A at erase start, result at bit 4
// - key_check_error reads 0 when the key held 5A at erase start
// - error protection entry sets the result bit and error_protect_flag
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
module fercc_top
	import fercc_pkg::*;
#(
	parameter int ERASE_CYC = FERCC_ERASE_CYC // erase pulse length in cycles
) (
	input  wire logic        I_CLK_SYS,       // 20 MHz system clock
	input  wire logic        I_NRST,          // async reset, active low
	input  wire logic        I_HSEL,          // ahb slave select
	input  wire logic [31:0] I_HADDR,         // ahb address
	input  wire logic [1:0]  I_HTRANS,        // ahb transfer type
	input  wire logic        I_HWRITE,        // ahb write
	input  wire logic [2:0]  I_HSIZE,         // ahb size, word only
	input  wire logic [31:0] I_HWDATA,        // ahb write data
	input  wire logic        I_HREADY,        // ahb bus ready
	output logic             O_HREADYOUT,     // slave ready
	output logic      [31:0] O_HRDATA,        // read data
	output logic             O_HRESP,         // always okay
	input  wire logic        I_BOOT_MODE,     // boot or programmer mode pin
	input  wire logic        I_PROTECT_ENTER, // error protection entry pin
	input  wire logic        I_ERASE_FAIL,    // flash macro erase failure
	output logic             O_ERASE_USER,    // erase user array
	output logic             O_ERASE_UBOOT,   // erase user boot array
	output logic             O_IRQ            // level interrupt
);

	// elaboration check on the erase count
	if (ERASE_CYC < FERCC_ERASE_CYC_MIN || ERASE_CYC > 65535) begin : g_chk
		$error("ERASE_CYC out of range");
	end

	// two-flop synchronisers for the three pins
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic       boot_s;
	logic       prot_s;
	logic       fail_s;

	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
		end else begin
			sync1_reg <= {I_ERASE_FAIL, I_PROTECT_ENTER, I_BOOT_MODE};
			sync2_reg <= sync1_reg;
		end
	end

	assign boot_s = sync2_reg[0];
	assign prot_s = sync2_reg[1];
	assign fail_s = sync2_reg[2];

	// read word decode, used by the read path
	function automatic logic [31:0] rd_word(
		input logic [7:0]             ofs,
		input logic [7:0]             key,
		input logic [7:0]             sel,
		input logic [7:0]             res,
		input logic                   error_protect_flag,
		input logic                   tgt,
		input logic [FERCC_IRQ_W-1:0] ist,
		input logic [FERCC_IRQ_W-1:0] msk
	);
		logic [31:0] w;
		w = FERCC_RST_WORD;
		unique case (ofs)
			FERCC_OFS_CTRL: w[FERCC_CTRL_TGT] = tgt;
			FERCC_OFS_KEY:  w[7:0] = key;
			FERCC_OFS_SEL:  w[7:0] = sel;
			FERCC_OFS_RES:  w[7:0] = res;
			FERCC_OFS_CCS:  w[FERCC_CCS_ERROR_PROTECT_FLAG] = error_protect_flag;
			FERCC_OFS_IST:  w[FERCC_IRQ_W-1:0] = ist;
			FERCC_OFS_IMSK: w[FERCC_IRQ_W-1:0] = msk;
			default:        w = FERCC_RST_WORD;
		endcase
		return w;
	endfunction

	// state registers and their next values
	fercc_state_t           state_reg, state_next;
	logic [15:0]            cnt_reg, cnt_next;
	logic [7:0]             key_reg, key_next;
	logic [7:0]             sel_reg, sel_next;
	logic [7:0]             res_reg, res_next;
	logic                   tgt_reg, tgt_next;
	logic                   error_protect_flag_reg, error_protect_flag_next;
	logic [FERCC_IRQ_W-1:0] ist_reg, ist_next;
	logic [FERCC_IRQ_W-1:0] imsk_reg, imsk_next;
	logic                   wpend_reg, wpend_next;
	logic [7:0]             waddr_reg, waddr_next;
	logic [31:0]            rdata_next;
	logic                   eu_next, eb_next, irq_next;
	logic                   ap_valid, wr_now, start, tamper;
	logic                   key_bad, sel_bad, chk_err;
	logic [FERCC_IRQ_W-1:0] ev, clr;

	// bus decode: address phase capture and data phase write
	assign ap_valid = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign wr_now   = wpend_reg;
	assign start    = wr_now && waddr_reg == FERCC_OFS_CTRL
		&& I_HWDATA[FERCC_CTRL_START];
	assign tamper   = wr_now && state_reg == FERCC_ERASE
		&& (waddr_reg == FERCC_OFS_CTRL || waddr_reg == FERCC_OFS_KEY
		|| waddr_reg == FERCC_OFS_SEL);

	// start checks: key, array selection and operating mode
	assign key_bad = key_reg != FERCC_KEY_UNLOCK;
	always_comb begin
		if (I_HWDATA[FERCC_CTRL_TGT])
			sel_bad = !boot_s || sel_reg != FERCC_SEL_UBOOT;
		else
			sel_bad = sel_reg == FERCC_SEL_UBOOT;
	end
	assign chk_err = key_bad || sel_bad || prot_s || error_protect_flag_reg;

	// next-state logic for bus, sequencer, results and interrupts
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		key_next   = key_reg;
		sel_next   = sel_reg;
		res_next   = res_reg;
		tgt_next   = tgt_reg;
		error_protect_flag_next  = error_protect_flag_reg | prot_s;
		imsk_next  = imsk_reg;
		eu_next    = 1'b0;
		eb_next    = 1'b0;
		ev         = '0;
		clr        = '0;
		wpend_next = ap_valid && I_HWRITE;
		waddr_next = ap_valid ? I_HADDR[7:0] : waddr_reg;
		rdata_next = FERCC_RST_WORD;
		if (ap_valid && !I_HWRITE) begin
			rdata_next = rd_word(I_HADDR[7:0], key_reg, sel_reg, res_reg,
				error_protect_flag_reg, tgt_reg, ist_reg, imsk_reg);
			if (I_HADDR[7:0] == FERCC_OFS_IST)
				clr = ist_reg; // read clears status
		end
		if (wr_now) begin
			unique case (waddr_reg)
				FERCC_OFS_KEY:  key_next = I_HWDATA[7:0];
				FERCC_OFS_SEL:  sel_next = I_HWDATA[7:0];
				FERCC_OFS_IMSK: imsk_next = I_HWDATA[FERCC_IRQ_W-1:0];
				default:        ;
			endcase
		end
		res_next[FERCC_RES_PROT] = error_protect_flag_next;
		unique case (state_reg)
			FERCC_IDLE: begin
				if (start) begin
					tgt_next = I_HWDATA[FERCC_CTRL_TGT];
					res_next[FERCC_RES_FK] = key_bad;
					res_next[FERCC_RES_EE] = sel_bad;
					if (chk_err) begin
						ev[FERCC_IRQ_DONE] = 1'b1;
						ev[FERCC_IRQ_ERR]  = 1'b1;
					end else begin
						state_next = FERCC_ERASE;
						cnt_next   = 16'(ERASE_CYC - 1);
						res_next[FERCC_RES_BUSY] = 1'b1;
						eu_next = !I_HWDATA[FERCC_CTRL_TGT];
						eb_next = I_HWDATA[FERCC_CTRL_TGT];
					end
				end
			end
			FERCC_ERASE: begin
				if (tamper || prot_s || fail_s || cnt_reg == 16'h0000) begin
					state_next = FERCC_IDLE;
					res_next[FERCC_RES_BUSY] = 1'b0;
					res_next[FERCC_RES_EE] = tamper || prot_s || fail_s;
					ev[FERCC_IRQ_DONE] = 1'b1;
					ev[FERCC_IRQ_ERR]  = tamper || prot_s || fail_s;
				end else begin
					cnt_next = cnt_reg - 16'h0001;
					eu_next  = !tgt_reg;
					eb_next  = tgt_reg;
				end
			end
		endcase
		ist_next = (ist_reg & ~clr) | ev; // set wins over read clear
		irq_next = |(ist_next & imsk_next);
	end

	// registers, all outputs come straight from here
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST) begin
			state_reg     <= FERCC_IDLE;
			cnt_reg       <= 16'h0000;
			key_reg       <= FERCC_RST_BYTE;
			sel_reg       <= FERCC_RST_BYTE;
			res_reg       <= FERCC_RST_BYTE;
			tgt_reg       <= 1'b0;
			error_protect_flag_reg      <= 1'b0;
			ist_reg       <= '0;
			imsk_reg      <= '0;
			wpend_reg     <= 1'b0;
			waddr_reg     <= FERCC_RST_BYTE;
			O_HREADYOUT   <= 1'b1;
			O_HRESP       <= 1'b0;
			O_HRDATA      <= FERCC_RST_WORD;
			O_ERASE_USER  <= 1'b0;
			O_ERASE_UBOOT <= 1'b0;
			O_IRQ         <= 1'b0;
		end else begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			key_reg       <= key_next;
			sel_reg       <= sel_next;
			res_reg       <= res_next;
			tgt_reg       <= tgt_next;
			error_protect_flag_reg      <= error_protect_flag_next;
			ist_reg       <= ist_next;
			imsk_reg      <= imsk_next;
			wpend_reg     <= wpend_next;
			waddr_reg     <= waddr_next;
			O_HREADYOUT   <= 1'b1;
			O_HRESP       <= 1'b0;
			O_HRDATA      <= rdata_next;
			O_ERASE_USER  <= eu_next;
			O_ERASE_UBOOT <= eb_next;
			O_IRQ         <= irq_next;
		end
	end

	// length of the running erase pulse, read only by the hold check
	logic [16:0] on_cnt_reg, on_cnt_next;

	// count cycles with an erase output high, zero while both are low
	always_comb begin
		if (O_ERASE_USER || O_ERASE_UBOOT)
			on_cnt_next = on_cnt_reg + 17'h0_0001;
		else
			on_cnt_next = 17'h0_0000;
	end

	// register the pulse length
	always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
		if (!I_NRST)
			on_cnt_reg <= 17'h0_0000;
		else
			on_cnt_reg <= on_cnt_next;
	end

	// checks on the sequencer and result bits
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_NRST);

	a_key_bad_flag: assert property (
		state_reg == FERCC_IDLE && start && key_bad
		|=> res_reg[FERCC_RES_FK] && !O_ERASE_USER && !O_ERASE_UBOOT)
		else $error("wrong key did not set key error");

	a_key_ok_clear: assert property (
		state_reg == FERCC_IDLE && start && !key_bad
		|=> !res_reg[FERCC_RES_FK])
		else $error("correct key left key error set");

	a_sel_mismatch: assert property (
		state_reg == FERCC_IDLE && start && !I_HWDATA[FERCC_CTRL_TGT]
		&& sel_reg == FERCC_SEL_UBOOT
		|=> res_reg[FERCC_RES_EE] && state_reg == FERCC_IDLE)
		else $error("boot select did not block user erase");

	a_no_cells_hit: assert property (
		state_reg == FERCC_IDLE && start && sel_bad
		|=> (!O_ERASE_USER && !O_ERASE_UBOOT)[*2])
		else $error("array erased despite mismatched select");

	a_uboot_mode: assert property (
		$rose(O_ERASE_UBOOT) |-> $past(boot_s)
		&& $past(sel_reg) == FERCC_SEL_UBOOT)
		else $error("boot array erased outside boot mode");

	a_tamper_err: assert property (
		tamper |=> res_reg[FERCC_RES_EE] && state_reg == FERCC_IDLE
		&& !O_ERASE_USER && !O_ERASE_UBOOT)
		else $error("register change during erase not flagged");

	a_fail_err: assert property (
		state_reg == FERCC_ERASE && fail_s
		|=> res_reg[FERCC_RES_EE] && ist_reg[FERCC_IRQ_ERR])
		else $error("erase failure not flagged");

	a_clean_end: assert property (
		state_reg == FERCC_ERASE && cnt_reg == 16'h0000 && !tamper
		&& !prot_s && !fail_s |=> !res_reg[FERCC_RES_EE])
		else $error("normal erase end flagged as error");

	a_prot_flag: assert property (
		prot_s |=> error_protect_flag_reg && res_reg[FERCC_RES_PROT])
		else $error("protection entry not reported");

	// an uncut erase keeps its output high for the full count
	a_erase_hold: assert property (
		state_reg == FERCC_ERASE && cnt_reg == 16'h0000 && !tamper
		&& !prot_s && !fail_s
		|-> on_cnt_reg == 17'(ERASE_CYC - 1)
		&& (O_ERASE_USER || O_ERASE_UBOOT))
		else $error("erase pulse cut short");

	a_irq_level: assert property (
		O_IRQ == |(ist_reg & imsk_reg))
		else $error("interrupt output disagrees with status");

	c_user_erase: cover property (
		$fell(O_ERASE_USER) && !res_reg[FERCC_RES_EE]);
	c_boot_erase: cover property ($rose(O_ERASE_UBOOT));
	c_key_error:  cover property (start && key_bad);
	c_tamper:     cover property (tamper);

endmodule // fercc_top

/* File: common/fercc_pkg.sv */
package fercc_pkg;

	// register byte offsets on the AHB-Lite port
	localparam logic [7:0] FERCC_OFS_CTRL = 8'h00; // start pulse and target
	localparam logic [7:0] FERCC_OFS_KEY  = 8'h04; // unlock_key_reg
	localparam logic [7:0] FERCC_OFS_SEL  = 8'h08; // array_select_reg
	localparam logic [7:0] FERCC_OFS_RES  = 8'h0C; // erase result bits
	localparam logic [7:0] FERCC_OFS_CCS  = 8'h10; // flash_ctrl_status_reg
	localparam logic [7:0] FERCC_OFS_IST  = 8'h14; // interrupt status
	localparam logic [7:0] FERCC_OFS_IMSK = 8'h18; // interrupt mask

	// field positions
	localparam int FERCC_CTRL_START = 0; // write 1 starts an erase
	localparam int FERCC_CTRL_TGT   = 1; // 0 user array, 1 user boot array
	localparam int FERCC_RES_BUSY   = 0; // erase in progress
	localparam int FERCC_RES_FK     = 4; // key_check_error
	localparam int FERCC_RES_EE     = 5; // erase_exec_error
	localparam int FERCC_RES_PROT   = 6; // error protection result
	localparam int FERCC_CCS_ERROR_PROTECT_FLAG   = 0; // error_protect_flag
	localparam int FERCC_IRQ_DONE   = 0; // erase attempt finished
	localparam int FERCC_IRQ_ERR    = 1; // attempt finished with an error
	localparam int FERCC_IRQ_W      = 2; // width of status and mask

	// key and select codes
	localparam logic [7:0] FERCC_KEY_UNLOCK = 8'h5A; // required unlock value
	localparam logic [7:0] FERCC_SEL_UBOOT  = 8'hAA; // selects user boot array

	// values after reset
	localparam logic [7:0]  FERCC_RST_BYTE = 8'h00;
	localparam logic [31:0] FERCC_RST_WORD = 32'h0000_0000;

	// erase pulse time, a least time rounded up to whole cycles
	localparam int FERCC_CLK_PERIOD_NS = 50;
	localparam int FERCC_ERASE_TIME_NS = 100_000;
	localparam int FERCC_ERASE_CYC     =
		(FERCC_ERASE_TIME_NS + FERCC_CLK_PERIOD_NS - 1) / FERCC_CLK_PERIOD_NS;
	localparam int FERCC_ERASE_CYC_MIN = 8; // shortest count the logic serves

	// erase sequencer states
	typedef enum logic [1:0] {
		FERCC_IDLE  = 2'b01,
		FERCC_ERASE = 2'b10
	} fercc_state_t;

endpackage : fercc_pkg

/* File: sim/fercc_top_tb.sv */
`define CHK(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("wrong value at %0t: got %h expected %h", \
				$time, got, exp); \
		end \
	end

module fercc_top_tb import fercc_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          CYC   = 16;                          // short erase
	localparam logic [31:0] C_USR = 32'h0000_0001;               // start user
	localparam logic [31:0] C_UBT = 32'h0000_0003;               // start boot
	localparam logic [31:0] ONES  = 32'hFFFF_FFFF;
	localparam logic [31:0] FK_B  = 32'h0000_0001 << FERCC_RES_FK;
	localparam logic [31:0] EE_B  = 32'h0000_0001 << FERCC_RES_EE;
	localparam logic [31:0] PR_B  = 32'h0000_0001 << FERCC_RES_PROT;
	localparam logic [31:0] RES_M = 32'h0000_0071;               // busy fk ee pr

	logic        clk, nrst, hsel, hwrite, boot, prot, fail;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic        hready, hresp, er_user, er_boot, irq;
	int          errors, total_checks, cycles;
	logic [7:0]  ofs_list [7];

	fercc_top #(.ERASE_CYC(CYC)) fercc_top_i (
		.I_CLK_SYS(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HREADYOUT(hready),
		.O_HRDATA(hrdata), .O_HRESP(hresp), .I_BOOT_MODE(boot),
		.I_PROTECT_ENTER(prot), .I_ERASE_FAIL(fail),
		.O_ERASE_USER(er_user), .O_ERASE_UBOOT(er_boot), .O_IRQ(irq)
	);

	// free running clock and hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	// one single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h00_0000, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
		`CHK(hresp, 1'b0)
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		ahb(1'b0, a, 32'h0000_0000, q);
		`CHK(q & m, e)
	endtask

	// erase outputs a little after the start write
	task automatic chk_pin(input logic u, input logic b);
		repeat (2) @(posedge clk);
		#1;
		`CHK({er_user, er_boot}, {u, b})
	endtask

	// poll busy until the attempt has ended
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			ahb(1'b0, FERCC_OFS_RES, 32'h0000_0000, q);
			n++;
		end while (q[FERCC_RES_BUSY] !== 1'b0 && n < 100);
		`CHK(q[FERCC_RES_BUSY], 1'b0)
	endtask

	task automatic done_test(input string s);
		$display("test %s done", s);
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// main sequence
	initial begin
		clk = 0; nrst = 0; hsel = 0; hwrite = 0; htrans = 2'b00;
		hsize = 3'b010; haddr = '0; hwdata = '0;
		boot = 0; prot = 0; fail = 0; errors = 0; total_checks = 0;
		cycles = 0;
		ofs_list = '{FERCC_OFS_KEY, FERCC_OFS_SEL, FERCC_OFS_RES,
			FERCC_OFS_CCS, FERCC_OFS_IST, FERCC_OFS_IMSK, 8'h3C};
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		foreach (ofs_list[k]) chk_rd(ofs_list[k], ONES, FERCC_RST_WORD);
		wr(8'h3C, ONES);
		chk_rd(8'h3C, ONES, FERCC_RST_WORD);
		done_test("reset");
		// wrong key, interrupt masked then enabled
		wr(FERCC_OFS_KEY, 32'h0000_0000);
		wr(FERCC_OFS_CTRL, C_USR);
		chk_pin(1'b0, 1'b0);
		chk_rd(FERCC_OFS_RES, FK_B, FK_B);
		`CHK(irq, 1'b0)
		chk_rd(FERCC_OFS_IST, 32'h0000_0003, 32'h0000_0003);
		wr(FERCC_OFS_IMSK, 32'h0000_0003);
		wr(FERCC_OFS_CTRL, C_USR);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b1)
		chk_rd(FERCC_OFS_IST, 32'h0000_0003, 32'h0000_0003);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		done_test("key");
		// user erase while the boot array is selected
		wr(FERCC_OFS_KEY, {24'h00_0000, FERCC_KEY_UNLOCK});
		wr(FERCC_OFS_SEL, {24'h00_0000, FERCC_SEL_UBOOT});
		wr(FERCC_OFS_CTRL, C_USR);
		chk_pin(1'b0, 1'b0);
		chk_rd(FERCC_OFS_RES, FK_B | EE_B, EE_B);
		done_test("select");
		// boot array erase outside and inside boot mode
		wr(FERCC_OFS_CTRL, C_UBT);
		chk_pin(1'b0, 1'b0);
		chk_rd(FERCC_OFS_RES, EE_B, EE_B);
		boot <= 1'b1;
		repeat (3) @(posedge clk);
		wr(FERCC_OFS_CTRL, C_UBT);
		chk_pin(1'b0, 1'b1);
		wait_idle();
		chk_rd(FERCC_OFS_RES, RES_M, 32'h0000_0000);
		chk_rd(FERCC_OFS_CTRL, 32'h0000_0002, 32'h0000_0002);
		boot <= 1'b0;
		done_test("boot");
		// clean user erase
		wr(FERCC_OFS_SEL, 32'h0000_0000);
		chk_rd(FERCC_OFS_IST, 32'h0000_0003, 32'h0000_0003);
		wr(FERCC_OFS_CTRL, C_USR);
		chk_pin(1'b1, 1'b0);
		repeat (CYC - 3) @(posedge clk);
		#1;
		`CHK(er_user, 1'b1)
		@(posedge clk);
		#1;
		`CHK(er_user, 1'b0)
		wait_idle();
		chk_rd(FERCC_OFS_RES, RES_M, 32'h0000_0000);
		chk_rd(FERCC_OFS_IST, 32'h0000_0003, 32'h0000_0001);
		done_test("erase");
		// register changed during an erase
		wr(FERCC_OFS_CTRL, C_USR);
		repeat (3) @(posedge clk);
		wr(FERCC_OFS_KEY, {24'h00_0000, FERCC_KEY_UNLOCK});
		wait_idle();
		chk_rd(FERCC_OFS_RES, EE_B, EE_B);
		`CHK(er_user, 1'b0)
		done_test("tamper");
		// erase failure, then repeat after the cause is gone
		wr(FERCC_OFS_CTRL, C_USR);
		fail <= 1'b1;
		wait_idle();
		fail <= 1'b0;
		chk_rd(FERCC_OFS_RES, EE_B, EE_B);
		repeat (4) @(posedge clk);
		wr(FERCC_OFS_CTRL, C_USR);
		wait_idle();
		chk_rd(FERCC_OFS_RES, EE_B, 32'h0000_0000);
		done_test("fail");
		// error protection entry
		prot <= 1'b1;
		repeat (4) @(posedge clk);
		chk_rd(FERCC_OFS_CCS, 32'h0000_0001, 32'h0000_0001);
		chk_rd(FERCC_OFS_RES, PR_B, PR_B);
		wr(FERCC_OFS_CTRL, C_USR);
		chk_pin(1'b0, 1'b0);
		done_test("protect");
		finish_test();
	end
endmodule // fercc_top_tb
